// [logic/wake_pkg.sv]
// Shared constants, commands and states of the sleep and wake controller.
// Assumes one system clock; pins are synchronised before logic reads them, except at the raw stop-wake gate.
package wake_pkg;
	localparam int BYTE_W = 8;
	localparam int NIB_W  = 4;
	localparam int VEC_W  = 3;
	localparam int PIN_W  = 10;

	// Source order shared by pending, release enable, mask and cause bits
	localparam int SRC_DIV0  = 0;
	localparam int SRC_TM0   = 1;
	localparam int SRC_PORTC = 2;
	localparam int SRC_PINA  = 3;
	localparam int SRC_DIV1  = 4;
	localparam int SRC_SER   = 5;
	localparam int SRC_PINB  = 6;
	localparam int SRC_TM1   = 7;

	// Pin vector layout: port C, port D, then the two edge pins
	localparam int PC_LO = 0;
	localparam int PC_HI = 3;
	localparam int PD_LO = 4;
	localparam int PD_HI = 7;
	localparam int PIN_A = 8;
	localparam int PIN_B = 9;

	// Edge hold enable keeps only its bits 2 and 3, stored here as 0 and 1
	localparam int EDGE_W   = 2;
	localparam int EDGE_A   = 0;
	localparam int EDGE_B   = 1;
	localparam int EDGE_OFS = 2;

	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
	localparam logic [NIB_W-1:0]  RST_NIB  = 4'h0;
	localparam logic [EDGE_W-1:0] RST_EDGE = 2'h0;
	localparam logic [PIN_W-1:0]  RST_PINS = 10'h000;
	localparam logic [PIN_W-1:0]  IDLE_PINS = 10'h3ff;
	localparam logic [VEC_W-1:0]  RST_VEC  = 3'h0;
	localparam logic [BYTE_W-1:0] ONE_HOT0 = 8'h01;

	typedef enum logic [4:0] {
		CMD_NOP      = 5'h00,
		CMD_STOP     = 5'h01,
		CMD_HOLD     = 5'h02,
		CMD_WR_SWE   = 5'h03,
		CMD_WR_HRE   = 5'h04,
		CMD_WR_HRED  = 5'h05,
		CMD_WR_IEM   = 5'h06,
		CMD_WR_PCE   = 5'h07,
		CMD_WR_EDGE  = 5'h08,
		CMD_CLR_EVP  = 5'h09,
		CMD_CLR_EVPD = 5'h0a,
		CMD_INT_ON   = 5'h0b,
		CMD_INT_OFF  = 5'h0c,
		CMD_RD_RCL   = 5'h0d,
		CMD_RD_RCH   = 5'h0e,
		CMD_RD_PSC   = 5'h0f,
		CMD_RD_PSD   = 5'h10,
		CMD_ISR_DONE = 5'h11
	} cmd_t;

	typedef enum logic [1:0] {
		MODE_RUN  = 2'b00,
		MODE_STOP = 2'b01,
		MODE_HOLD = 2'b10,
		MODE_ISR  = 2'b11
	} mode_t;
endpackage : wake_pkg

// [logic/wake_link_if.sv]
// Carrier between the controller, the pin synchroniser and the arbiter.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ps
interface wake_link_if;
	import wake_pkg::*;
	logic [PIN_W-1:0]  pinRaw;
	logic [PIN_W-1:0]  rise;
	logic [PIN_W-1:0]  fall;
	logic [BYTE_W-1:0] pending;
	logic              globalEn;
	logic              ack;
	logic              req;
	logic [VEC_W-1:0]  vector;

	modport sync (input pinRaw, output rise, fall);
	modport arb  (input pending, globalEn, ack, output req, vector);
	modport ctrl (output pinRaw, pending, globalEn, ack,
		input rise, fall, req, vector);
endinterface : wake_link_if

// [logic/pin_edge_sync.sv]
// Two-stage synchroniser and edge detector for the wake and change pins.
// Assumes pins are asynchronous to mclk; edges are one-cycle pulses.
`timescale 1ns/1ps
module pin_edge_sync
	import wake_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	wake_link_if.sync link
);
	typedef struct packed {
		logic [PIN_W-1:0] meta;
		logic [PIN_W-1:0] stable;
		logic [PIN_W-1:0] prev;
	} sync_t;

	sync_t cur;
	sync_t next_cur;

	// Idle-high reset matches pulled-up pins; a pin low at reset gives one fall
	always_comb begin
		next_cur        = cur;
		next_cur.meta   = link.pinRaw;
		next_cur.stable = cur.meta;
		next_cur.prev   = cur.stable;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{IDLE_PINS, IDLE_PINS, IDLE_PINS};
		end else begin
			cur <= next_cur;
		end
	end

	// Each edge lasts one cycle, so it is counted exactly once
	assign link.rise = cur.stable & ~cur.prev;
	assign link.fall = ~cur.stable & cur.prev;
endmodule : pin_edge_sync

// [logic/irq_arbiter.sv]
// Picks the lowest-numbered enabled pending source and raises a request.
// Assumes the controller clears the taken source and the global enable.
`timescale 1ns/1ps
module irq_arbiter
	import wake_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	wake_link_if.arb link
);
	typedef struct packed {
		logic             req;
		logic [VEC_W-1:0] vector;
	} arb_t;

	arb_t cur;
	arb_t next_cur;

	function automatic logic [VEC_W-1:0] firstSet(
		input logic [BYTE_W-1:0] bits);
		logic [VEC_W-1:0] idx;
		idx = RST_VEC;
		for (int i = BYTE_W - 1; i >= 0; i--) begin
			if (bits[i]) begin
				idx = VEC_W'(i);
			end
		end
		return idx;
	endfunction : firstSet

	// Drop the request on the acknowledge edge so it cannot be taken twice
	always_comb begin
		next_cur     = cur;
		next_cur.req = (|link.pending) && link.globalEn && !link.ack;
		if (!cur.req || link.ack) begin
			next_cur.vector = firstSet(link.pending);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{1'b0, RST_VEC};
		end else begin
			cur <= next_cur;
		end
	end

	assign link.req    = cur.req;
	assign link.vector = cur.vector;
endmodule : irq_arbiter

// [logic/sleep_wake_ctrl.sv]
// Stop and hold sleep control with wake, release and interrupt gating.
// Assumes a core that issues commands on mclk and is halted by coreHalt.
`timescale 1ns/1ps
module sleep_wake_ctrl
	import wake_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              cmdValid,
	input  wire logic [4:0]        cmdOp,
	input  wire logic [BYTE_W-1:0] cmdData,
	output      logic [NIB_W-1:0]  readData,
	output      logic              coreHalt,
	input  wire logic              slowMode,
	output      logic              mainOscEnable,
	output      logic              subOscEnable,
	input  wire logic              div0Overflow,
	input  wire logic              timer0Underflow,
	input  wire logic              div1Overflow,
	input  wire logic              serialDone,
	input  wire logic              timer1Underflow,
	input  wire logic [NIB_W-1:0]  wakePortC,
	input  wire logic [NIB_W-1:0]  wakePortD,
	input  wire logic              extIrqPinA,
	input  wire logic              extIrqPinB,
	output      logic              irqReq,
	output      logic [VEC_W-1:0]  irqVector,
	input  wire logic              irqAck
);
	typedef struct packed {
		mode_t             mode;
		logic [BYTE_W-1:0] stopWakeEnable;
		logic [BYTE_W-1:0] holdReleaseEnable;
		logic              holdReleaseEnablePortD;
		logic [BYTE_W-1:0] irqEnableMask;
		logic [BYTE_W-1:0] pinChangeEnable;
		logic [EDGE_W-1:0] extEdgeHoldEnable;
		logic [BYTE_W-1:0] releaseCause;
		logic              releaseCausePortD;
		logic [BYTE_W-1:0] eventPending;
		logic              eventPendingPortD;
		logic [NIB_W-1:0]  pinChangeSourceC;
		logic [NIB_W-1:0]  pinChangeSourceD;
		logic              irqEnable;
		logic [BYTE_W-1:0] stopSnap;
		logic [NIB_W-1:0]  readData;
	} ctrl_t;

	ctrl_t cur;
	ctrl_t next_cur;

	wake_link_if link ();

	pin_edge_sync u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.link    (link.sync)
	);

	irq_arbiter u_arb (
		.mclk    (mclk),
		.reset_n (reset_n),
		.link    (link.arb)
	);

	logic              cmdLive;
	logic              ackLive;
	logic              asyncWake;
	logic              stopWake;
	logic              anyCause;
	logic [NIB_W-1:0]  chgC;
	logic [NIB_W-1:0]  chgD;
	logic              chgPortD;
	logic [BYTE_W-1:0] evSet;
	logic [BYTE_W-1:0] relGate;
	logic [BYTE_W-1:0] causeSet;

	assign link.pinRaw = {extIrqPinB, extIrqPinA, wakePortD, wakePortC};
	assign link.pending = cur.eventPending & cur.irqEnableMask;
	assign link.globalEn = cur.irqEnable;
	assign link.ack = irqAck;

	assign coreHalt = (cur.mode == MODE_STOP) || (cur.mode == MODE_HOLD);
	assign cmdLive  = cmdValid && !coreHalt;
	assign ackLive  = irqAck && link.req && (cur.mode != MODE_STOP);
	assign anyCause = (|cur.releaseCause) || cur.releaseCausePortD;

	// Raw pins against the level caught at entry: works with mclk stopped
	assign asyncWake = (cur.mode == MODE_STOP) &&
		(|(cur.stopWakeEnable & cur.stopSnap &
		~link.pinRaw[PD_HI:PC_LO]));
	assign stopWake = |(cur.stopWakeEnable & link.fall[PD_HI:PC_LO]);

	assign mainOscEnable = (cur.mode != MODE_STOP) || asyncWake;
	assign subOscEnable  = !((cur.mode == MODE_STOP) && slowMode) ||
		asyncWake;

	// Change means either edge on a pin whose change enable is set
	assign chgC = (link.rise[PC_HI:PC_LO] | link.fall[PC_HI:PC_LO]) &
		cur.pinChangeEnable[PC_HI:PC_LO];
	assign chgD = (link.rise[PD_HI:PD_LO] | link.fall[PD_HI:PD_LO]) &
		cur.pinChangeEnable[PD_HI:PD_LO];
	assign chgPortD = |chgD;

	always_comb begin
		evSet            = RST_BYTE;
		evSet[SRC_DIV0]  = div0Overflow;
		evSet[SRC_TM0]   = timer0Underflow;
		evSet[SRC_PORTC] = |chgC;
		evSet[SRC_PINA]  = link.fall[PIN_A];
		evSet[SRC_DIV1]  = div1Overflow;
		evSet[SRC_SER]   = serialDone;
		evSet[SRC_PINB]  = link.fall[PIN_B];
		evSet[SRC_TM1]   = timer1Underflow;
		relGate           = ~RST_BYTE;
		relGate[SRC_PINA] = cur.extEdgeHoldEnable[EDGE_A];
		relGate[SRC_PINB] = cur.extEdgeHoldEnable[EDGE_B];
		causeSet = evSet & cur.holdReleaseEnable & relGate;
	end

	always_comb begin
		logic [BYTE_W-1:0] evClr;
		logic [BYTE_W-1:0] causeClr;
		logic              evDClr;
		logic              causeDClr;
		logic              psrCClr;
		logic              psrDClr;
		evClr     = RST_BYTE;
		causeClr  = RST_BYTE;
		evDClr    = 1'b0;
		causeDClr = 1'b0;
		psrCClr   = 1'b0;
		psrDClr   = 1'b0;
		next_cur  = cur;

		if (cmdLive) begin
			case (cmdOp)
				CMD_WR_SWE: begin
					next_cur.stopWakeEnable = cmdData;
				end
				CMD_WR_HRE: begin
					next_cur.holdReleaseEnable = cmdData;
					causeClr = causeClr | ~cmdData;
				end
				CMD_WR_HRED: begin
					next_cur.holdReleaseEnablePortD = cmdData[0];
					causeDClr = !cmdData[0];
				end
				CMD_WR_IEM: begin
					next_cur.irqEnableMask = cmdData;
					next_cur.irqEnable = 1'b1;
				end
				CMD_WR_PCE: begin
					next_cur.pinChangeEnable = cmdData;
				end
				CMD_WR_EDGE: begin
					next_cur.extEdgeHoldEnable =
						cmdData[EDGE_OFS+EDGE_W-1:EDGE_OFS];
				end
				CMD_CLR_EVP: begin
					evClr    = cmdData;
					causeClr = causeClr | cmdData;
					psrCClr  = cmdData[SRC_PORTC];
				end
				CMD_CLR_EVPD: begin
					evDClr    = 1'b1;
					causeDClr = 1'b1;
					psrDClr   = 1'b1;
				end
				CMD_INT_ON: begin
					next_cur.irqEnable = 1'b1;
				end
				CMD_INT_OFF: begin
					next_cur.irqEnable = 1'b0;
				end
				CMD_RD_RCL: begin
					next_cur.readData = cur.releaseCause[NIB_W-1:0];
				end
				CMD_RD_RCH: begin
					next_cur.readData =
						cur.releaseCause[BYTE_W-1:NIB_W];
				end
				CMD_RD_PSC: begin
					next_cur.readData = cur.pinChangeSourceC;
				end
				CMD_RD_PSD: begin
					next_cur.readData = cur.pinChangeSourceD;
				end
				default: begin
				end
			endcase
		end

		// A take clears only its own source and shuts the global enable
		if (ackLive) begin
			evClr = evClr | (ONE_HOT0 << link.vector);
			next_cur.irqEnable = 1'b0;
		end

		// Set wins over clear in every flag
		next_cur.eventPending = (cur.eventPending & ~evClr) | evSet;
		next_cur.eventPendingPortD =
			(cur.eventPendingPortD && !evDClr) || chgPortD;
		next_cur.releaseCause =
			(cur.releaseCause & ~causeClr) | causeSet;
		next_cur.releaseCausePortD = (cur.releaseCausePortD && !causeDClr) ||
			(chgPortD && cur.holdReleaseEnablePortD);
		next_cur.pinChangeSourceC =
			(cur.pinChangeSourceC & ~{NIB_W{psrCClr}}) | chgC;
		next_cur.pinChangeSourceD =
			(cur.pinChangeSourceD & ~{NIB_W{psrDClr}}) | chgD;

		unique case (cur.mode)
			MODE_RUN: begin
				if (cmdLive && cmdOp == CMD_STOP) begin
					next_cur.mode = MODE_STOP;
					next_cur.stopSnap = link.pinRaw[PD_HI:PC_LO];
				end else if (cmdLive && cmdOp == CMD_HOLD) begin
					next_cur.mode = MODE_HOLD;
				end
			end
			MODE_STOP: begin
				if (stopWake) begin
					next_cur.mode = MODE_RUN;
				end
			end
			MODE_HOLD: begin
				if (anyCause) begin
					next_cur.mode = MODE_RUN;
				end else if (ackLive) begin
					next_cur.mode = MODE_ISR;
				end
			end
			MODE_ISR: begin
				if (cmdLive && cmdOp == CMD_ISR_DONE) begin
					next_cur.mode = MODE_HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{MODE_RUN, RST_BYTE, RST_BYTE, 1'b0, RST_BYTE,
				RST_BYTE, RST_EDGE, RST_BYTE, 1'b0, RST_BYTE, 1'b0,
				RST_NIB, RST_NIB, 1'b0, RST_BYTE, RST_NIB};
		end else begin
			cur <= next_cur;
		end
	end

	assign readData  = cur.readData;
	assign irqReq    = link.req;
	assign irqVector = link.vector;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence s_stopArmed;
		cur.mode == MODE_STOP && stopWake;
	endsequence
	sequence s_resumed;
		cur.mode == MODE_RUN ##0 !coreHalt;
	endsequence

	property p_stop_halts;
		cur.mode == MODE_STOP && !asyncWake |-> coreHalt && !mainOscEnable;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("stop did not halt");

	property p_stop_wake;
		s_stopArmed |=> s_resumed;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("stop wake did not resume");

	property p_slow_stop;
		cur.mode == MODE_STOP && slowMode && !asyncWake |-> !subOscEnable;
	endproperty
	a_slow_stop: assert property (p_slow_stop)
		else $error("sub oscillator ran in slow stop");

	property p_hold_runs;
		cur.mode == MODE_HOLD |-> coreHalt && mainOscEnable && subOscEnable;
	endproperty
	a_hold_runs: assert property (p_hold_runs)
		else $error("hold state wrong");

	property p_hold_release;
		cur.mode == MODE_HOLD && anyCause |=> cur.mode == MODE_RUN;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("hold not released by cause");

	property p_cause_set;
		div0Overflow && cur.holdReleaseEnable[SRC_DIV0] |=>
			cur.releaseCause[SRC_DIV0] && cur.eventPending[SRC_DIV0];
	endproperty
	a_cause_set: assert property (p_cause_set)
		else $error("cause not recorded");

	property p_cause_clear;
		cmdLive && cmdOp == CMD_WR_HRE && !cmdData[SRC_TM0] &&
			!timer0Underflow |=> !cur.releaseCause[SRC_TM0];
	endproperty
	a_cause_clear: assert property (p_cause_clear)
		else $error("cause survived enable clear");

	property p_take_one;
		ackLive && !(|evSet) && !cmdLive |=> cur.eventPending ==
			($past(cur.eventPending) & ~(ONE_HOT0 << $past(link.vector)));
	endproperty
	a_take_one: assert property (p_take_one)
		else $error("take disturbed other pending bits");

	property p_take_inhibit;
		ackLive && !cmdLive |=> !cur.irqEnable ##1 !irqReq;
	endproperty
	a_take_inhibit: assert property (p_take_inhibit)
		else $error("interrupts not inhibited after take");

	property p_isr_return;
		cur.mode == MODE_ISR && cmdLive && cmdOp == CMD_ISR_DONE |=>
			cur.mode == MODE_HOLD ##0 coreHalt;
	endproperty
	a_isr_return: assert property (p_isr_return)
		else $error("no return to hold after routine");
endmodule : sleep_wake_ctrl

// [dv/core_model.sv]
// Core-side model: issues commands and takes interrupts.
// Assumes commands are taken on the mclk edge where cmdValid is high.
`timescale 1ns/1ps
module core_model
	import wake_pkg::*;
(
	input  wire logic              mclk,
	output      logic              cmdValid,
	output      logic [4:0]        cmdOp,
	output      logic [BYTE_W-1:0] cmdData,
	output      logic              irqAck
);
	initial begin
		cmdValid = 1'b0;
		cmdOp    = CMD_NOP;
		cmdData  = 8'h00;
		irqAck   = 1'b0;
	end

	// Operands are not held between commands, so idle shows the inverse
	task automatic issue(input cmd_t op, input logic [BYTE_W-1:0] d);
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmdOp    <= op;
		cmdData  <= d;
		@(posedge mclk);
		cmdValid <= 1'b0;
		cmdOp    <= ~op;
		cmdData  <= ~d;
	endtask : issue

	// Stale causes would end the hold at once, so they go first
	task automatic hold_entry;
		issue(CMD_CLR_EVP, 8'hff);
		issue(CMD_CLR_EVPD, 8'h00);
		issue(CMD_HOLD, 8'h00);
	endtask : hold_entry

	// Commands are refused while halted, so the no-op follows the wake
	task automatic stop_entry;
		issue(CMD_STOP, 8'h00);
	endtask : stop_entry

	task automatic take_irq;
		@(posedge mclk);
		irqAck <= 1'b1;
		@(posedge mclk);
		irqAck <= 1'b0;
	endtask : take_irq
endmodule : core_model

// [dv/sleep_wake_and_interrupt_enable_test.sv]
// Self-checking bench for the sleep and wake controller.
// Assumes the core model drives commands and takes interrupts.
`timescale 1ns/1ps
module sleep_wake_and_interrupt_enable_test
	import wake_pkg::*;
;
	logic              mclk;
	logic              reset_n;
	logic              cmdValid;
	logic [4:0]        cmdOp;
	logic [BYTE_W-1:0] cmdData;
	logic [NIB_W-1:0]  readData;
	logic              coreHalt;
	logic              slowMode;
	logic              mainOscEnable;
	logic              subOscEnable;
	logic              div0Overflow;
	logic              timer0Underflow;
	logic              div1Overflow;
	logic              serialDone;
	logic              timer1Underflow;
	logic [NIB_W-1:0]  wakePortC;
	logic [NIB_W-1:0]  wakePortD;
	logic              extIrqPinA;
	logic              extIrqPinB;
	logic              irqReq;
	logic [VEC_W-1:0]  irqVector;
	logic              irqAck;
	int                nMismatch;
	int                testsRun;

	sleep_wake_ctrl i_dut (.mclk(mclk), .reset_n(reset_n),
		.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData),
		.readData(readData), .coreHalt(coreHalt), .slowMode(slowMode),
		.mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable),
		.div0Overflow(div0Overflow), .timer0Underflow(timer0Underflow),
		.div1Overflow(div1Overflow), .serialDone(serialDone),
		.timer1Underflow(timer1Underflow), .wakePortC(wakePortC),
		.wakePortD(wakePortD), .extIrqPinA(extIrqPinA),
		.extIrqPinB(extIrqPinB), .irqReq(irqReq), .irqVector(irqVector),
		.irqAck(irqAck));

	core_model i_core (.mclk(mclk), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdData(cmdData), .irqAck(irqAck));

	task automatic test_done;
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		testsRun++;
		if (g !== e) begin
			nMismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cmd(input cmd_t o, input logic [7:0] d);
		i_core.issue(o, d);
		#1;
	endtask : cmd

	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle

	// Bounded wait on the halt (sel 0) or the request (sel 1)
	task automatic wait_for(input bit sel, input logic e);
		for (int k = 0; k < 12 && (sel ? irqReq : coreHalt) !== e; k++)
			idle(1);
		chk(sel ? "irqReq" : "coreHalt", e, sel ? irqReq : coreHalt);
	endtask : wait_for

	task automatic ev(input logic [7:0] m);
		@(posedge mclk);
		div0Overflow    <= m[0];
		timer0Underflow <= m[1];
		wakePortC[0]    <= wakePortC[0] ^ m[2];
		extIrqPinA      <= extIrqPinA & ~m[3];
		div1Overflow    <= m[4];
		serialDone      <= m[5];
		extIrqPinB      <= extIrqPinB & ~m[6];
		timer1Underflow <= m[7];
		@(posedge mclk);
		{div0Overflow, timer0Underflow, div1Overflow} <= 3'h0;
		{serialDone, timer1Underflow} <= 2'h0;
		#1;
	endtask : ev

	task automatic pins_idle;
		@(posedge mclk);
		wakePortC <= 4'hf;
		wakePortD <= 4'hf;
		{extIrqPinA, extIrqPinB} <= 2'h3;
		idle(5);
	endtask : pins_idle

	task automatic rd_cause(input logic [7:0] e);
		cmd(CMD_RD_RCL, 8'h00);
		chk("causeLow", e[3:0], readData);
		cmd(CMD_RD_RCH, 8'h00);
		chk("causeHigh", e[7:4], readData);
	endtask : rd_cause

	task automatic t_reset;
		chk("coreHalt", 1'b0, coreHalt);
		chk("mainOsc", 1'b1, mainOscEnable);
		chk("irqReq", 1'b0, irqReq);
		rd_cause(8'h00);
	endtask : t_reset

	task automatic t_hold_release;
		cmd(CMD_WR_PCE, 8'hff);
		cmd(CMD_WR_EDGE, 8'h0c);
		for (int i = 0; i < 8; i++) begin
			cmd(CMD_WR_HRE, 8'h01 << i);
			i_core.hold_entry();
			#1;
			chk("coreHalt", 1'b1, coreHalt);
			ev(8'h01 << i);
			wait_for(1'b0, 1'b0);
			rd_cause(8'h01 << i);
			if (i == SRC_PORTC) begin
				cmd(CMD_RD_PSC, 8'h00);
				chk("portCSource", 8'h01, readData);
			end
			// Odd sources clear by the enable, even ones by the pending bit
			if (i[0])
				cmd(CMD_WR_HRE, 8'h00);
			else
				cmd(CMD_CLR_EVP, 8'h01 << i);
			rd_cause(8'h00);
			pins_idle();
		end
	endtask : t_hold_release

	task automatic t_port_d;
		cmd(CMD_WR_HRE, 8'h00);
		cmd(CMD_WR_HRED, 8'h01);
		i_core.hold_entry();
		ev(8'h02);
		idle(8);
		chk("coreHalt", 1'b1, coreHalt);
		chk("mainOsc", 1'b1, mainOscEnable);
		chk("subOsc", 1'b1, subOscEnable);
		@(posedge mclk);
		wakePortD[1] <= 1'b0;
		wait_for(1'b0, 1'b0);
		rd_cause(8'h00);
		cmd(CMD_RD_PSD, 8'h00);
		chk("portDSource", 8'h02, readData);
		pins_idle();
	endtask : t_port_d

	task automatic t_irq;
		cmd(CMD_CLR_EVP, 8'hff);
		cmd(CMD_WR_IEM, 8'h12);
		cmd(CMD_INT_ON, 8'h00);
		ev(8'h12);
		wait_for(1'b1, 1'b1);
		chk("irqVector", 8'h01, irqVector);
		i_core.take_irq();
		idle(6);
		chk("irqReq", 1'b0, irqReq);
		cmd(CMD_WR_IEM, 8'h12);
		wait_for(1'b1, 1'b1);
		chk("irqVector", 8'h04, irqVector);
		i_core.take_irq();
		cmd(CMD_WR_IEM, 8'h01);
		cmd(CMD_INT_OFF, 8'h00);
		ev(8'h01);
		idle(6);
		chk("irqReq", 1'b0, irqReq);
		cmd(CMD_INT_ON, 8'h00);
		wait_for(1'b1, 1'b1);
		chk("irqVector", 8'h00, irqVector);
		i_core.take_irq();
	endtask : t_irq

	task automatic t_isr_hold;
		cmd(CMD_WR_IEM, 8'h80);
		i_core.hold_entry();
		ev(8'h80);
		wait_for(1'b1, 1'b1);
		chk("irqVector", 8'h07, irqVector);
		i_core.take_irq();
		wait_for(1'b0, 1'b0);
		cmd(CMD_ISR_DONE, 8'h00);
		wait_for(1'b0, 1'b1);
		@(posedge mclk);
		wakePortD[2] <= 1'b0;
		wait_for(1'b0, 1'b0);
		cmd(CMD_WR_IEM, 8'h00);
		pins_idle();
	endtask : t_isr_hold

	task automatic t_stop;
		@(posedge mclk);
		slowMode <= 1'b1;
		cmd(CMD_WR_SWE, 8'h01);
		i_core.stop_entry();
		#1;
		chk("coreHalt", 1'b1, coreHalt);
		chk("mainOsc", 1'b0, mainOscEnable);
		chk("subOsc", 1'b0, subOscEnable);
		@(posedge mclk);
		wakePortD[0] <= 1'b0;
		idle(8);
		chk("coreHalt", 1'b1, coreHalt);
		@(posedge mclk);
		wakePortC[0] <= 1'b0;
		#1;
		chk("mainOsc", 1'b1, mainOscEnable);
		wait_for(1'b0, 1'b0);
		cmd(CMD_NOP, 8'h00);
	endtask : t_stop

	// Pins go high first, so the reset does not leave a false fall behind
	task automatic t_reset_mid;
		cmd(CMD_WR_HRE, 8'hff);
		ev(8'h01);
		cmd(CMD_RD_RCL, 8'h00);
		chk("causeLow", 8'h01, readData);
		pins_idle();
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		#1;
		chk("readData", 8'h00, readData);
		chk("coreHalt", 1'b0, coreHalt);
		chk("irqReq", 1'b0, irqReq);
		ev(8'h01);
		idle(2);
		rd_cause(8'h00);
	endtask : t_reset_mid

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		repeat (5000) @(posedge mclk);
		nMismatch++;
		$display("watchdog ran out");
		test_done();
	end

	initial begin
		nMismatch = 0;
		testsRun = 0;
		reset_n = 1'b0;
		slowMode = 1'b0;
		{div0Overflow, timer0Underflow, div1Overflow} = 3'h0;
		{serialDone, timer1Underflow} = 2'h0;
		wakePortC = 4'hf;
		wakePortD = 4'hf;
		{extIrqPinA, extIrqPinB} = 2'h3;
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		#1;
		t_reset();
		t_hold_release();
		t_port_d();
		t_irq();
		t_isr_hold();
		t_stop();
		t_reset_mid();
		test_done();
	end
endmodule : sleep_wake_and_interrupt_enable_test
